// ===== verilog/dmc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"
// Notes on behaviour
// - A one in the halver bypass bit skips the divide-by-2 stage, per selected main converter page.
// - The digital hold bit resets to one, holds the digital logic in reset, and zero releases it.
// - With sync combine set on a dual link, the two link sync outputs act as one.
// - Bit 5 of the link mode field picks single (0) or dual (1) link, reset 0x20.
// - The low five bits of the link mode field pick the link operating mode.
// - The main interpolation field decodes 1,2,4,6,8,12 and resets to 8.
// - The channel interpolation field decodes 1,2,3,4,6,8 and resets to 4.
// - Link register bit 7 is read-only status, reset zero, untouched by writes.
// - The loop lock status reads one once the delay-locked loop has locked.
module dmc_top #(
  parameter int          PAGES       = 2,
  parameter logic [4:0]  MAX_MODE    = 5'h17
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  // register port
  input  wire dmc_pkg::dmc_req_t       req_i,
  output var  logic [7:0]              rd_data_o,
  // status pins
  input  wire logic                    dll_lock_i,
  input  wire logic [1:0]              link_sync_req_i,
  // configuration out
  output var  dmc_pkg::dmc_cfg_t       cfg_o,
  output var  logic [1:0]              link_sync_outputs_o,
  output var  logic                    mode_unsupported_o
);
  import dmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic main_rate_ok(input logic [3:0] c);
    main_rate_ok = (c == 4'h1) || (c == 4'h2) || (c == 4'h4) ||
                   (c == 4'h6) || (c == 4'h8) || (c == 4'hC);
  endfunction

  function automatic logic ch_rate_ok(input logic [3:0] c);
    ch_rate_ok = (c == 4'h1) || (c == 4'h2) || (c == 4'h3) ||
                 (c == 4'h4) || (c == 4'h6) || (c == 4'h8);
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_a);
    hit = (a == ref_a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [PAGES-1:0] page_r;
  logic [PAGES-1:0] halver_r;
  logic             hold_r;
  logic             combine_r;
  logic [5:0]       mode_r;
  logic [3:0]       main_r;
  logic [3:0]       ch_r;
  logic             unsup_r;
  logic             unsup_nxt;
  logic             lock_q;
  logic [1:0]       sync_q;
  logic [7:0]       rd_nxt;
  logic             halver_rd;
  logic             wr_page;
  logic             wr_modsw;
  logic             wr_hold;
  logic             wr_link;
  logic             wr_interp;

  localparam logic [5:0] RST_MODE = `DMC_RST_MODE;

  assign wr_page   = req_i.wr && hit(req_i.addr, `DMC_ADDR_PAGE);
  assign wr_modsw  = req_i.wr && hit(req_i.addr, `DMC_ADDR_MODSW);
  assign wr_hold   = req_i.wr && hit(req_i.addr, `DMC_ADDR_HOLD);
  assign wr_link   = req_i.wr && hit(req_i.addr, `DMC_ADDR_LINK);
  assign wr_interp = req_i.wr && hit(req_i.addr, `DMC_ADDR_INTERP);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  dmc_sync #(
    .W (1)
  ) u_lock_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (dll_lock_i),
    .q_o    (lock_q)
  );

  // requests are active low, so reset to the idle level
  dmc_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_link_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (link_sync_req_i),
    .q_o    (sync_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // page select

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      page_r <= PAGES'(`DMC_RST_PAGE);
    end else if (wr_page) begin
      page_r <= req_i.wdata[PAGES-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halver bypass, one bit per page

  genvar p;
  generate
    for (p = 0; p < PAGES; p++) begin : g_page
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          halver_r[p] <= `DMC_RST_HALVER;
        end else if (wr_modsw && page_r[p]) begin
          halver_r[p] <= req_i.wdata[`DMC_BIT_HALVER];
        end
      end
    end
  endgenerate

  // lowest selected page answers reads
  always_comb begin
    halver_rd = 1'b0;
    for (int i = PAGES - 1; i >= 0; i--) begin
      if (page_r[i]) begin
        halver_rd = halver_r[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digital hold

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_r <= `DMC_RST_HOLD;
    end else if (wr_hold) begin
      hold_r <= req_i.wdata[`DMC_BIT_HOLD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link mode

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      combine_r <= `DMC_RST_COMBINE;
      mode_r    <= `DMC_RST_MODE;
    end else if (wr_link) begin
      combine_r <= req_i.wdata[`DMC_BIT_COMBINE];
      mode_r    <= req_i.wdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interpolation rates

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_r <= `DMC_RST_MAIN;
      ch_r   <= `DMC_RST_CH;
    end else if (wr_interp) begin
      main_r <= req_i.wdata[7:4];
      ch_r   <= req_i.wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unsupported combination status, never written by software

  always_comb begin
    unsup_nxt = !main_rate_ok(main_r) || !ch_rate_ok(ch_r) ||
                (mode_r[4:0] > MAX_MODE);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      unsup_r <= `DMC_RST_UNSUP;
    end else begin
      unsup_r <= unsup_nxt;
    end
  end

  assign mode_unsupported_o = unsup_r;

  ////////////////////////////////////////////////////////////////////////////
  // link sync outputs

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_sync_outputs_o <= 2'h3;
    end else if (combine_r && mode_r[`DMC_BIT_DUAL]) begin
      link_sync_outputs_o <= {2{&sync_q}};
    end else begin
      link_sync_outputs_o <= sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration outputs

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_o <= '{digital_logic_hold_bit: `DMC_RST_HOLD,
                 mod_path_halver_bypass: 2'h0,
                 dual_link:              RST_MODE[`DMC_BIT_DUAL],
                 sync_output_combine:    1'b0,
                 link_mode_code:         RST_MODE[4:0],
                 main_path_interp_rate:  `DMC_RST_MAIN,
                 channel_interp_rate:    `DMC_RST_CH};
    end else begin
      cfg_o.digital_logic_hold_bit <= hold_r;
      cfg_o.mod_path_halver_bypass <= 2'(halver_r);
      cfg_o.dual_link              <= mode_r[`DMC_BIT_DUAL];
      cfg_o.sync_output_combine    <= combine_r && mode_r[`DMC_BIT_DUAL];
      cfg_o.link_mode_code         <= mode_r[4:0];
      cfg_o.main_path_interp_rate  <= main_r;
      cfg_o.channel_interp_rate    <= ch_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_comb begin
    rd_nxt = 8'h00;
    unique case (req_i.addr)
      `DMC_ADDR_PAGE:     rd_nxt = 8'(page_r);
      `DMC_ADDR_DLL_STAT: rd_nxt = {7'h00, lock_q};
      `DMC_ADDR_MODSW:    rd_nxt = {6'h00, halver_rd, 1'b0};
      `DMC_ADDR_HOLD:     rd_nxt = {7'h00, hold_r};
      `DMC_ADDR_LINK:     rd_nxt = {unsup_r, combine_r, mode_r};
      `DMC_ADDR_INTERP:   rd_nxt = {main_r, ch_r};
      default:            rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
    end else if (req_i.rd) begin
      rd_data_o <= rd_nxt;
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_hold_clear;
    req_i.wr && req_i.addr == `DMC_ADDR_HOLD && !req_i.wdata[0];
  endsequence

  sequence s_hold_out_low;
    !hold_r ##1 !cfg_o.digital_logic_hold_bit;
  endsequence

  chk_hold_release: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    s_hold_clear |=> s_hold_out_low)
    else $error("hold not released after clearing write");

  chk_hold_steady: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !wr_hold |=> $stable(hold_r))
    else $error("hold bit moved without a write");

  chk_halver_page: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    wr_modsw && page_r[0] |=> ##1
      cfg_o.mod_path_halver_bypass[0] == $past(req_i.wdata[1], 2))
    else $error("halver bypass not taken on selected page");

  chk_halver_other: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    wr_modsw && !page_r[1] |=> $stable(halver_r[1]))
    else $error("unselected page halver changed");

  chk_dual_link: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    wr_link |=> ##1 cfg_o.dual_link == $past(req_i.wdata[5], 2))
    else $error("dual link flag wrong after mode write");

  chk_sync_combine: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    combine_r && mode_r[5] && sync_q != 2'h3 |=> link_sync_outputs_o == 2'h0)
    else $error("combined sync outputs not merged");

  chk_status_ro: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    wr_link && req_i.wdata[`DMC_BIT_UNSUP] && !unsup_nxt |=> !unsup_r)
    else $error("status bit followed a write");

  chk_unsup_rate: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    wr_interp && req_i.wdata[3:0] == 4'h5 |=> ##1 unsup_r)
    else $error("illegal channel rate not flagged");

  chk_interp_write: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    wr_interp |=> ##1 {cfg_o.main_path_interp_rate, cfg_o.channel_interp_rate}
      == $past(req_i.wdata, 2))
    else $error("interpolation rates not taken");

  chk_lock_read: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    dll_lock_i [*5] ##0 (req_i.rd && req_i.addr == `DMC_ADDR_DLL_STAT)
      |=> rd_data_o == 8'h01)
    else $error("lock status not read back");

  chk_lock_low: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!dll_lock_i) [*5] ##0 (req_i.rd && req_i.addr == `DMC_ADDR_DLL_STAT)
      |=> rd_data_o == 8'h00)
    else $error("lock status read high while unlocked");

  chk_mode_code: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    wr_link |=> ##1 cfg_o.link_mode_code == $past(req_i.wdata[4:0], 2))
    else $error("link mode code not taken");

  chk_sync_merged: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    cfg_o.sync_output_combine |-> link_sync_outputs_o[0] == link_sync_outputs_o[1])
    else $error("sync outputs differ while combined");

  chk_unsup_clear: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    wr_interp && main_rate_ok(req_i.wdata[7:4]) && ch_rate_ok(req_i.wdata[3:0]) &&
      (mode_r[4:0] <= MAX_MODE) |=> ##1 !unsup_r)
    else $error("supported combination flagged");

  chk_read_idle: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !req_i.rd |=> rd_data_o == 8'h00)
    else $error("read data present without a read");
endmodule
`default_nettype wire

// ===== pkg/dmc_map.svh
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
// register offsets
`define DMC_ADDR_PAGE     12'h008
`define DMC_ADDR_DLL_STAT 12'h0C3
`define DMC_ADDR_MODSW    12'h0FF
`define DMC_ADDR_HOLD     12'h100
`define DMC_ADDR_LINK     12'h110
`define DMC_ADDR_INTERP   12'h111
// field positions
`define DMC_BIT_HALVER    1
`define DMC_BIT_HOLD      0
`define DMC_BIT_UNSUP     7
`define DMC_BIT_COMBINE   6
`define DMC_BIT_DUAL      5
// reset values
`define DMC_RST_PAGE      2'h3
`define DMC_RST_HOLD      1'h1
`define DMC_RST_MODE      6'h20
`define DMC_RST_MAIN      4'h8
`define DMC_RST_CH        4'h4
`define DMC_RST_HALVER    1'h0
`define DMC_RST_COMBINE   1'h0
`define DMC_RST_UNSUP     1'h0
`endif

// ===== pkg/dmc_pkg.sv
package dmc_pkg;
  typedef struct packed {
    logic       digital_logic_hold_bit;
    logic [1:0] mod_path_halver_bypass;
    logic       dual_link;
    logic       sync_output_combine;
    logic [4:0] link_mode_code;
    logic [3:0] main_path_interp_rate;
    logic [3:0] channel_interp_rate;
  } dmc_cfg_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } dmc_req_t;
endpackage

// ===== verilog/dmc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dmc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          q_o[g] <= RST_VAL[g];
        end else if (s2_r[g] == s3_r[g]) begin
          q_o[g] <= s3_r[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"
module testbench;
  import dmc_pkg::*;
  logic              clk_i;
  logic              nrst_i;
  logic              dll_lock_i;
  logic [1:0]        link_sync_req_i;
  logic [1:0]        link_sync_outputs_o;
  dmc_req_t          req_i;
  logic [7:0]        rd_data_o;
  dmc_cfg_t          cfg_o;
  logic              mode_unsupported_o;
  logic [7:0]        exp_q[$];
  logic              pend;
  int                n_mismatch;
  int                num_checks;
  logic [3:0]        mains[6] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC};
  logic [3:0]        chans[6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
  logic [3:0]        m;
  logic [3:0]        c;

  dmc_top #(.PAGES(2), .MAX_MODE(5'h17)) dmc_top_inst (
    .clk_i               (clk_i),
    .nrst_i              (nrst_i),
    .req_i               (req_i),
    .rd_data_o           (rd_data_o),
    .dll_lock_i          (dll_lock_i),
    .link_sync_req_i     (link_sync_req_i),
    .cfg_o               (cfg_o),
    .link_sync_outputs_o (link_sync_outputs_o),
    .mode_unsupported_o  (mode_unsupported_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, watchdog, tasks
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    #(50 * 1000);
    n_mismatch++;
    summarize();
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
  endtask

  task automatic nop(input int n);
    req_i <= '{addr: 12'h000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    repeat (n) @(posedge clk_i);
  endtask

  task automatic endt(input string s);
    $display("test %s finished", s);
  endtask

  function automatic logic bad(input logic [3:0] mm, input logic [3:0] cc);
    bad = !(mm inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC}) ||
          !(cc inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8});
  endfunction

  // read monitor: data stand the cycle after the strobe
  always @(posedge clk_i) begin
    if (pend) begin
      check(rd_data_o, exp_q.pop_front());
    end
    pend <= req_i.rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    nrst_i = 1'b0;
    req_i = '0;
    dll_lock_i = 1'b0;
    link_sync_req_i = 2'b11;
    pend = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(95));
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(`DMC_ADDR_PAGE, 8'h03);
    rd(`DMC_ADDR_MODSW, 8'h00);
    rd(`DMC_ADDR_HOLD, 8'h01);
    rd(`DMC_ADDR_LINK, 8'h20);
    rd(`DMC_ADDR_INTERP, 8'h84);
    rd(`DMC_ADDR_DLL_STAT, 8'h00);
    rd(12'h123, 8'h00);
    nop(2);
    check(8'(cfg_o.digital_logic_hold_bit), 8'h01);
    check(8'(cfg_o.dual_link), 8'h01);
    check({cfg_o.main_path_interp_rate, cfg_o.channel_interp_rate}, 8'h84);
    check(8'(link_sync_outputs_o), 8'h03);
    endt("reset");
    wr(`DMC_ADDR_LINK, 8'hA5);
    rd(`DMC_ADDR_LINK, 8'h25);
    nop(2);
    check(8'(cfg_o.link_mode_code), 8'h05);
    wr(`DMC_ADDR_LINK, 8'h38);
    nop(2);
    check(8'(mode_unsupported_o), 8'h01);
    rd(`DMC_ADDR_LINK, 8'hB8);
    wr(`DMC_ADDR_LINK, 8'h37);
    nop(2);
    check(8'(mode_unsupported_o), 8'h00);
    rd(`DMC_ADDR_LINK, 8'h37);
    endt("link mode");
    for (int i = 0; i < 12; i++) begin
      m = (i < 6) ? mains[i] : 4'($urandom_range(15));
      c = (i < 6) ? chans[i] : (i == 6) ? 4'h5 : 4'($urandom_range(15));
      wr(`DMC_ADDR_INTERP, {m, c});
      nop(2);
      check({cfg_o.main_path_interp_rate, cfg_o.channel_interp_rate}, {m, c});
      check(8'(mode_unsupported_o), 8'(bad(m, c)));
      rd(`DMC_ADDR_INTERP, {m, c});
    end
    wr(`DMC_ADDR_INTERP, 8'h84);
    endt("rates");
    wr(`DMC_ADDR_PAGE, 8'h01);
    wr(`DMC_ADDR_MODSW, 8'hFF);
    nop(2);
    check(8'(cfg_o.mod_path_halver_bypass), 8'h01);
    rd(`DMC_ADDR_MODSW, 8'h02);
    wr(`DMC_ADDR_PAGE, 8'h02);
    wr(`DMC_ADDR_MODSW, 8'h00);
    wr(`DMC_ADDR_PAGE, 8'h03);
    nop(2);
    check(8'(cfg_o.mod_path_halver_bypass), 8'h01);
    rd(`DMC_ADDR_MODSW, 8'h02);
    endt("paging");
    dll_lock_i <= 1'b1;
    nop(6);
    rd(`DMC_ADDR_DLL_STAT, 8'h01);
    wr(`DMC_ADDR_HOLD, 8'h00);
    nop(2);
    check(8'(cfg_o.digital_logic_hold_bit), 8'h00);
    rd(`DMC_ADDR_HOLD, 8'h00);
    endt("hold");
    wr(`DMC_ADDR_LINK, 8'h60);
    link_sync_req_i <= 2'b10;
    nop(6);
    check(8'(link_sync_outputs_o), 8'h00);
    check(8'(cfg_o.sync_output_combine), 8'h01);
    wr(`DMC_ADDR_LINK, 8'h40);
    nop(3);
    check(8'(link_sync_outputs_o), 8'h02);
    check(8'(cfg_o.dual_link), 8'h00);
    endt("sync");
    nrst_i <= 1'b0;
    nop(1);
    nrst_i <= 1'b1;
    rd(`DMC_ADDR_HOLD, 8'h01);
    rd(`DMC_ADDR_LINK, 8'h20);
    nop(2);
    endt("second reset");
    summarize();
  end
endmodule
`default_nettype wire
